// File: rtl/atsc_pkg.sv
// Shared constants and carrier types of the antenna tuner servo control
package atsc_pkg;

  // Clock and brake pulse timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BRAKE_TIME_NS = 1000;
  localparam int BRAKE_CYCLES =
    (BRAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TUNE_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;

  // Status register field positions
  localparam int STAT_CAPHOME_BIT = 0;
  localparam int STAT_INDHOME_BIT = 1;
  localparam int STAT_INDFORCE_BIT = 2;
  localparam int STAT_DRV_LSB = 8;
  localparam int STAT_SENSE_LSB = 16;

  // Sensor and link inputs, polarity as on the pins
  typedef struct packed {
    logic phasePos;
    logic phaseNeg;
    logic magHigh;
    logic magLow;
    logic indMinN;
    logic capMaxN;
    logic matchHigh;
    logic matchLowN;
    logic tune;
    logic auxInhibitN;
  } atsc_sense_t;

  // Servo drives and condition outputs
  typedef struct packed {
    logic capDec;
    logic capInc;
    logic indInc;
    logic indDec;
    logic posHighN;
    logic seriesStepN;
    logic minMaxN;
    logic brake;
  } atsc_drive_t;

  localparam atsc_sense_t SENSE_RST = 10'h035;
  localparam atsc_drive_t DRIVE_RST = 8'h0e;

endpackage

// File: rtl/atsc_servo_ctrl.sv
// Servo direction logic, home/force latches and condition detectors
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

module atsc_servo_ctrl #(
  parameter int BRAKE_CYCLES = atsc_pkg::BRAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // Sensor pins
  input wire atsc_pkg::atsc_sense_t sensePins,
  // Servo drives and condition outputs
  output atsc_pkg::atsc_drive_t drive
);

  if (BRAKE_CYCLES < 1 || BRAKE_CYCLES > 255) begin : gBadBrake
    $error("BRAKE_CYCLES must lie in 1..255");
  end

  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    atsc_pkg::atsc_sense_t s1;
    atsc_pkg::atsc_sense_t s2;
    atsc_pkg::atsc_sense_t s3;
    atsc_pkg::atsc_sense_t flt;
    logic capHome;
    logic indHome;
    logic indForce;
    logic matchPrev;
    logic [7:0] brakeCnt;
    logic ctrlEn;
    logic swTune;
    logic waitReq;
    logic [31:0] rdData;
    atsc_pkg::atsc_drive_t drv;
  } atsc_state_t;

  atsc_state_t st_r;
  atsc_state_t st_nxt;

  atsc_pkg::atsc_sense_t f;
  logic posHigh;
  logic zeroHigh;
  logic minMax;
  logic tuneNow;
  logic capSup;
  logic indSup;
  logic matchNow;
  logic accept;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;

    // Three-stage synchroniser; a change counts when stages 2 and 3 agree
    st_nxt.s1 = sensePins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.flt = (st_r.s2 & st_r.s3) | (st_r.flt & (st_r.s2 | st_r.s3));
    f = st_r.flt;

    posHigh = f.phasePos & f.magHigh;
    // Zero phase, not below 50, inductor minimum, capacitor not max
    zeroHigh = !f.phasePos & !f.phaseNeg & !f.magLow
      & !f.indMinN
      & f.capMaxN & !st_r.capHome;
    minMax = !f.indMinN & !f.capMaxN;
    tuneNow = f.tune | st_r.swTune;
    matchNow = f.matchHigh & !f.matchLowN;

    // Clear takes precedence over set in the same cycle
    if (!f.capMaxN || posHigh) begin
      st_nxt.capHome = 1'b0;
    end else if (tuneNow) begin
      st_nxt.capHome = 1'b1;
    end
    if (posHigh || !f.indMinN) begin
      st_nxt.indHome = 1'b0;
    end else if (tuneNow) begin
      st_nxt.indHome = 1'b1;
    end
    if (posHigh) begin
      st_nxt.indForce = 1'b0;
    end else if (minMax && f.auxInhibitN) begin
      st_nxt.indForce = 1'b1;
    end

    // Brake pulse on each rising match indication
    st_nxt.matchPrev = matchNow;
    if (matchNow && !st_r.matchPrev) begin
      st_nxt.brakeCnt = 8'(BRAKE_CYCLES);
    end else if (st_r.brakeCnt != 8'h00) begin
      st_nxt.brakeCnt = st_r.brakeCnt - 8'h01;
    end

    // Error drives are cut while a home drive acts, so an error drive never
    // opposes a home drive; indHome and indForce both set drive indInc and indDec at once
    capSup = st_r.capHome | f.matchHigh;
    indSup = st_r.indHome | st_r.indForce | f.matchHigh;

    st_nxt.drv.capDec = st_r.ctrlEn & f.phasePos & !capSup;
    st_nxt.drv.capInc = st_r.ctrlEn
      & (st_r.capHome | (f.phaseNeg & !capSup));
    st_nxt.drv.indInc = st_r.ctrlEn
      & (st_r.indForce | (f.magLow & !indSup));
    st_nxt.drv.indDec = st_r.ctrlEn
      & (st_r.indHome | (f.magHigh & !indSup));
    st_nxt.drv.posHighN = !posHigh;
    st_nxt.drv.seriesStepN = !zeroHigh;
    st_nxt.drv.minMaxN = !minMax;
    st_nxt.drv.brake = st_r.brakeCnt != 8'h00;

    // Avalon slave: one wait cycle, then the answer
    accept = (avsRead | avsWrite) & st_r.waitReq;
    st_nxt.waitReq = !accept;
    st_nxt.swTune = 1'b0;
    if (avsWrite && !st_r.waitReq && avsAddress == atsc_pkg::CTRL_OFS) begin
      st_nxt.ctrlEn = avsWritedata[atsc_pkg::CTRL_EN_BIT];
      st_nxt.swTune = avsWritedata[atsc_pkg::CTRL_TUNE_BIT];
    end
    st_nxt.rdData = 32'h0;
    if (accept && avsRead) begin
      case (avsAddress)
        atsc_pkg::CTRL_OFS: begin
          st_nxt.rdData[atsc_pkg::CTRL_EN_BIT] = st_r.ctrlEn;
        end
        atsc_pkg::STAT_OFS: begin
          st_nxt.rdData[atsc_pkg::STAT_CAPHOME_BIT] = st_r.capHome;
          st_nxt.rdData[atsc_pkg::STAT_INDHOME_BIT] = st_r.indHome;
          st_nxt.rdData[atsc_pkg::STAT_INDFORCE_BIT] = st_r.indForce;
          st_nxt.rdData[atsc_pkg::STAT_DRV_LSB +: 8] = st_r.drv;
          st_nxt.rdData[atsc_pkg::STAT_SENSE_LSB +: 10] = st_r.flt;
        end
        default: begin
          st_nxt.rdData = 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Latches clear on reset, standing in for power-up clearing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.ctrlEn <= atsc_pkg::CTRL_EN_RST;
      st_r.waitReq <= 1'b1;
      st_r.drv <= atsc_pkg::DRIVE_RST;
      // Idle pin levels, so no false end stop or match edge after reset
      st_r.s1 <= atsc_pkg::SENSE_RST;
      st_r.s2 <= atsc_pkg::SENSE_RST;
      st_r.s3 <= atsc_pkg::SENSE_RST;
      st_r.flt <= atsc_pkg::SENSE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive = st_r.drv;
  assign avsReaddata = st_r.rdData;
  assign avsWaitrequest = st_r.waitReq;

  ////////////////////////////////////////////////////////////////////
  posHigh_out_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (drive.posHighN == !$past(posHigh)))
    else $error("positive-high output wrong");

  zeroDet_a: assert property (@(posedge clk) disable iff (!nrst)
    (!drive.seriesStepN) |-> $past(!st_r.flt.phasePos && !st_r.flt.phaseNeg
      && !st_r.flt.magLow && !st_r.flt.indMinN))
    else $error("series step without zero phase high");

  zeroInhibit_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.capHome || !st_r.flt.capMaxN) |=> drive.seriesStepN)
    else $error("series step while inhibited");

  minMax_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_r.flt.indMinN && !st_r.flt.capMaxN) |=> !drive.minMaxN)
    else $error("min/max output missing");

  capHomeClr_a: assert property (@(posedge clk) disable iff (!nrst)
    (posHigh || !st_r.flt.capMaxN) |=> !st_r.capHome)
    else $error("capacitor home not cleared");

  indHomeSet_a: assert property (@(posedge clk) disable iff (!nrst)
    (tuneNow && !posHigh && st_r.flt.indMinN && st_r.ctrlEn)
    |=> st_r.indHome ##1 drive.indDec)
    else $error("inductor home not driving down");

  forceGate_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_r.indForce && !st_r.flt.auxInhibitN) |=> !st_r.indForce)
    else $error("force latch set while inhibited");

  capExcl_a: assert property (@(posedge clk) disable iff (!nrst)
    !(drive.capDec && drive.capInc))
    else $error("both capacitor directions driven");

  matchStop_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.flt.matchHigh && !st_r.capHome && !st_r.indHome && !st_r.indForce)
    |=> !(drive.capDec || drive.capInc || drive.indInc || drive.indDec))
    else $error("drive present while match high");

  brake_a: assert property (@(posedge clk) disable iff (!nrst)
    (matchNow && !st_r.matchPrev) |=> ##1 drive.brake)
    else $error("brake pulse missing");

  ////////////////////////////////////////////////////////////////////
  // Per-rule checks, one edge after the filtered cause

  posHighLow_a: assert property (@(posedge clk) disable iff (!nrst)
    (f.phasePos && f.magHigh)
    |=> !drive.posHighN)
    else $error("positive-high output not low");

  posHighIdle_a: assert property (@(posedge clk) disable iff (!nrst)
    !(f.phasePos && f.magHigh)
    |=> drive.posHighN)
    else $error("positive-high output low without cause");

  zeroSet_a: assert property (@(posedge clk) disable iff (!nrst)
    (!f.phasePos && !f.phaseNeg && !f.magLow && !f.indMinN && f.capMaxN && !st_r.capHome)
    |=> !drive.seriesStepN)
    else $error("series step request missing");

  zeroNeedMin_a: assert property (@(posedge clk) disable iff (!nrst)
    f.indMinN
    |=> drive.seriesStepN)
    else $error("series step without inductor minimum");

  zeroPhase_a: assert property (@(posedge clk) disable iff (!nrst)
    (f.phasePos || f.phaseNeg || f.magLow)
    |=> drive.seriesStepN)
    else $error("series step with phase or low error");

  minMaxIdle_a: assert property (@(posedge clk) disable iff (!nrst)
    (f.indMinN || f.capMaxN)
    |=> drive.minMaxN)
    else $error("min/max output low without cause");

  forceSet_a: assert property (@(posedge clk) disable iff (!nrst)
    (!f.indMinN && !f.capMaxN && f.auxInhibitN && !posHigh)
    |=> st_r.indForce)
    else $error("force latch not set");

  capDecDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.ctrlEn && f.phasePos && !st_r.capHome && !f.matchHigh)
    |=> drive.capDec)
    else $error("capacitance decrease drive missing");

  capIncDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.ctrlEn && f.phaseNeg && !f.matchHigh)
    |=> drive.capInc)
    else $error("capacitance increase drive missing");

  indIncDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.ctrlEn && f.magLow && !st_r.indHome && !st_r.indForce && !f.matchHigh)
    |=> drive.indInc)
    else $error("inductance increase drive missing");

  indDecDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.ctrlEn && f.magHigh && !st_r.indHome && !st_r.indForce && !f.matchHigh)
    |=> drive.indDec)
    else $error("inductance decrease drive missing");

  capHomeSet_a: assert property (@(posedge clk) disable iff (!nrst)
    (tuneNow && !posHigh && f.capMaxN)
    |=> st_r.capHome)
    else $error("capacitor home not set");

  capHomeDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.capHome && st_r.ctrlEn)
    |=> drive.capInc)
    else $error("capacitor home not driving up");

  capHomeSup_a: assert property (@(posedge clk) disable iff (!nrst)
    st_r.capHome
    |=> !drive.capDec)
    else $error("phase drive while capacitor homes");

  indHomeClr_a: assert property (@(posedge clk) disable iff (!nrst)
    (posHigh || !f.indMinN)
    |=> !st_r.indHome)
    else $error("inductor home not cleared");

  indForceDrv_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.indForce && st_r.ctrlEn)
    |=> drive.indInc)
    else $error("force latch not driving up");

  forceOnly_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_r.indForce && (f.indMinN || f.capMaxN))
    |=> !st_r.indForce)
    else $error("force latch set without min/max");

  forceClr_a: assert property (@(posedge clk) disable iff (!nrst)
    posHigh
    |=> !st_r.indForce)
    else $error("force latch not cleared");

  tuneCapSup_a: assert property (@(posedge clk) disable iff (!nrst)
    (f.tune && f.matchHigh && !st_r.capHome)
    |=> (!drive.capDec && !drive.capInc))
    else $error("capacitor drive during tune pulse");

  homeIndSup_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.indHome && !st_r.indForce)
    |=> !drive.indInc)
    else $error("error drive while inductor homes");

  forceIndSup_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.indForce && !st_r.indHome)
    |=> !drive.indDec)
    else $error("error drive while inductor forced");

  matchInd_a: assert property (@(posedge clk) disable iff (!nrst)
    (f.matchHigh && !st_r.indHome && !st_r.indForce)
    |=> (!drive.indInc && !drive.indDec))
    else $error("inductor drive while match high");

  brakeStart_a: assert property (@(posedge clk) disable iff (!nrst)
    (matchNow && !st_r.matchPrev)
    |=> (st_r.brakeCnt == 8'(BRAKE_CYCLES)))
    else $error("brake count not loaded");

  brakeOn_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.brakeCnt != 8'h00)
    |=> drive.brake)
    else $error("brake output low while counting");

  brakeOff_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r.brakeCnt == 8'h00)
    |=> !drive.brake)
    else $error("brake output high when idle");

  enGate_a: assert property (@(posedge clk) disable iff (!nrst)
    !st_r.ctrlEn
    |=> !(drive.capDec || drive.capInc || drive.indInc || drive.indDec))
    else $error("servo drive while disabled");

  clearWins_a: assert property (@(posedge clk) disable iff (!nrst)
    (tuneNow && posHigh)
    |=> (!st_r.capHome && !st_r.indHome))
    else $error("home latch set against clear");

  syncChain_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (st_r.s3
    == $past(st_r.s2)))
    else $error("synchroniser stage skipped");

  waitOne_a: assert property (@(posedge clk) disable iff (!nrst)
    !avsWaitrequest
    |=> avsWaitrequest)
    else $error("waitrequest low for more than one cycle");

endmodule // atsc_servo_ctrl

// File: test/atsc_far_side.sv
// Far-side model: sensors, control board and auxiliary board
`timescale 1ns/1ps

module atsc_far_side (
  // Scene set by the bench
  input wire atsc_pkg::atsc_sense_t scene,
  input wire logic stepAway,
  // Pins toward the block
  output atsc_pkg::atsc_sense_t sensePins
);
  always_comb begin
    sensePins = scene;
    sensePins.matchHigh = scene.matchHigh | scene.tune;
    // Board reads the raw end stops, so inhibit lands with the condition
    sensePins.auxInhibitN = !(stepAway && !scene.indMinN && !scene.capMaxN);
  end
endmodule // atsc_far_side

// File: test/antenna_tuner_servo_control_bench.sv
// Self-checking bench of the antenna tuner servo control
`timescale 1ns/1ps

module antenna_tuner_servo_control_bench;
  localparam int BC = 4;
  typedef struct packed {
    logic [9:0] sense;
    logic [7:0] drv;
  } atsc_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  atsc_pkg::atsc_sense_t scene = 10'h175;
  logic stepAway = 1'b0;
  atsc_pkg::atsc_sense_t sensePins;
  atsc_pkg::atsc_drive_t drive;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;
  atsc_row_t rows [6] = '{'{10'h2b5, 8'h96}, '{10'h175, 8'h6e}, '{10'h275, 8'hae},
    '{10'h095, 8'h1a}, '{10'h0b5, 8'h1e}, '{10'h17d, 8'h0e}};

  atsc_far_side atsc_far_side_inst (.scene(scene), .stepAway(stepAway), .sensePins(sensePins));
  atsc_servo_ctrl #(.BRAKE_CYCLES(BC)) atsc_servo_ctrl_inst (.clk(clk), .nrst(nrst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .sensePins(sensePins), .drive(drive));

  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Extra idle edge at the end keeps back-to-back calls from double driving
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0) @(posedge clk);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask

  // Input filter plus output register take five edges
  task automatic settle(input atsc_pkg::atsc_sense_t s);
    scene <= s;
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check(drive, atsc_pkg::DRIVE_RST);
    bus(1'b0, atsc_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, atsc_pkg::STAT_OFS, 32'h0);
    check(rd[2:0], 3'h0);
    bus(1'b1, 4'h8, 32'hffff_ffff);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      settle(rows[i].sense);
      check(drive, rows[i].drv);
    end
    bus(1'b1, atsc_pkg::CTRL_OFS, 32'h0);
    settle(10'h2b5);
    check({drive.capDec, drive.capInc, drive.indInc, drive.indDec}, 4'h0);
    bus(1'b1, atsc_pkg::CTRL_OFS, 32'h1);
    scene <= 10'h179;
    n = 0;
    while (drive.brake !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (drive.brake === 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check(n, BC);
    // Tune pulse held long enough to pass the filter
    scene <= 10'h277;
    repeat (6) @(posedge clk);
    settle(10'h275);
    check(drive, 8'h5e);
    bus(1'b0, atsc_pkg::STAT_OFS, 32'h0);
    check(rd[2:0], 3'h3);
    settle(10'h265);
    check(drive, 8'h9e);
    settle(10'h185);
    check(drive, 8'h6c);
    bus(1'b0, atsc_pkg::STAT_OFS, 32'h0);
    check(rd[2:0], 3'h4);
    settle(10'h2b5);
    check(drive, 8'h96);
    stepAway <= 1'b1;
    settle(10'h185);
    check(drive, 8'h5c);
    // Software tune through the control register
    stepAway <= 1'b0;
    settle(10'h175);
    bus(1'b1, atsc_pkg::CTRL_OFS, 32'h3);
    bus(1'b0, atsc_pkg::STAT_OFS, 32'h0);
    check(rd[2:0], 3'h3);
    bus(1'b0, atsc_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    repeat (2) @(posedge clk);
    check(drive, 8'h5e);
    summarize();
  end
endmodule // antenna_tuner_servo_control_bench
